// >>> logic/mrs_sequencer.sv
// integrate-hold-readout sequencer with ahb-lite control registers
`include "mrs_regs.svh"
`default_nettype none
module mrs_sequencer #(
    parameter int SWEEP_PER_CYC = `MRS_SWEEP_PER_US * `MRS_CLK_MHZ,
    parameter int INTEG_RST_CYC = `MRS_DISCH_TC_NUM * `MRS_DISCH_TC_MS * 1000 * `MRS_CLK_MHZ,
    parameter int RELAY_CYC     = `MRS_RELAY_US * `MRS_CLK_MHZ,
    parameter int DEBOUNCE_CYC  = `MRS_DEBOUNCE_MS * 1000 * `MRS_CLK_MHZ
) (
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // front panel pins, asynchronous
    input  wire logic                 start_btn,
    input  wire logic                 sweep_rst_btn,
    input  wire logic                 man_adv_btn,
    input  wire logic                 print_force_sw,
    input  wire logic                 recycle_sw,
    // timing and switching references, asynchronous
    input  wire logic                 tick_1hz,
    input  wire logic                 sig_ref_sw,
    // integrator values, same clock domain
    input  wire logic [51:0][7:0]     integ_val,
    // integrator and detector control
    output logic                      integ_reset,
    output logic                      integ_hold,
    output logic                      det_sw_sig,
    output logic                      det_sw_ref,
    // readout
    output logic                      print_gate,
    output logic                      print_relay,
    output logic                      end_of_readout,
    output logic [5:0]                lamp_code,
    output logic [5:0]                dac_code,
    output mrs_pkg::mrs_gate_drv_t    gate_drv,
    output logic [51:0]               chan_sel,
    output logic [51:0][7:0]          gated_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    mrs_pkg::mrs_regs_t r_ff;      // registered state
    mrs_pkg::mrs_regs_t nxt_r;     // next state

    // decoded helpers
    logic        start_pls;        // start from pin or register
    logic        swrst_pls;        // sweep reset from pin or register
    logic        adv_pls;          // pushbutton advance
    logic [2:0]  btn_rise;         // debounced button rising edges
    logic        tick_pls;         // one pulse per second
    logic        base_pls;         // astable base pulse
    logic        sweep_pls;        // divided sweep pulse
    logic        advance;          // scaler step

    logic [3:0]  rate_eff;         // rate in force
    logic [9:0]  rate_mask;        // low divider bits for this rate
    logic [9:0]  t_target;         // selected integration seconds

    logic        hold_lvl;         // integrators held
    logic        pgate;            // print command gating
    logic [31:0] rd_word;          // read mux
    logic [5:0]  wr_last;          // clamped channel count

    // register command strobes
    logic        cmd_start;
    logic        cmd_swrst;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;

        // two-stage synchronisers for every asynchronous pin
        nxt_r.sync1 = {sig_ref_sw, tick_1hz, recycle_sw, print_force_sw,
                       man_adv_btn, sweep_rst_btn, start_btn};
        nxt_r.sync2 = r_ff.sync1;

        // debounce buttons
        // a level must stand a full count
        // so contact bounce never steps twice
        for (int i = 0; i < 3; i++) begin
            if (r_ff.sync2[i] == r_ff.btn_level[i]) begin
                nxt_r.deb_cnt[i] = 21'h0;
            end else if (r_ff.deb_cnt[i] == 21'(DEBOUNCE_CYC - 1)) begin
                nxt_r.deb_cnt[i]   = 21'h0;
                nxt_r.btn_level[i] = r_ff.sync2[i];
            end else begin
                nxt_r.deb_cnt[i] = r_ff.deb_cnt[i] + 21'h1;
            end
        end
        btn_rise = nxt_r.btn_level & ~r_ff.btn_level;

        // bus phase capture; writes land in the data phase
        cmd_start = 1'b0;
        cmd_swrst = 1'b0;
        wr_last   = hwdata[`MRS_CTRL_LAST_MSB:`MRS_CTRL_LAST_LSB];
        // channel count held within one to 52
        if (wr_last == 6'h00) begin
            wr_last = 6'h01;
        end else if (wr_last > `MRS_MAX_CHAN) begin
            wr_last = `MRS_MAX_CHAN;
        end
        if (r_ff.ph_valid && r_ff.ph_write) begin
            if (r_ff.ph_addr == `MRS_CTRL_OFS) begin
                nxt_r.auto_en   = hwdata[`MRS_CTRL_AUTO_BIT];
                nxt_r.rate_sel  = hwdata[`MRS_CTRL_RATE_MSB:`MRS_CTRL_RATE_LSB];
                nxt_r.time_sel  = hwdata[`MRS_CTRL_TSEL_MSB:`MRS_CTRL_TSEL_LSB];
                nxt_r.last_chan = wr_last;
            end else if (r_ff.ph_addr == `MRS_CMD_OFS) begin
                cmd_start = hwdata[`MRS_CMD_START_BIT];
                cmd_swrst = hwdata[`MRS_CMD_SWRST_BIT];
            end
        end

        start_pls = r_ff.auto_en && (btn_rise[0] || cmd_start);
        swrst_pls = btn_rise[1] || cmd_swrst;
        adv_pls   = btn_rise[2];

        nxt_r.tick_prev = r_ff.sync2[5];
        tick_pls        = r_ff.sync2[5] && !r_ff.tick_prev;

        base_pls = (r_ff.base_cnt == 21'(SWEEP_PER_CYC - 1));
        // base pulse also clocks the divider
        if (base_pls) begin
            nxt_r.base_cnt = 21'h0;
            nxt_r.div_cnt  = r_ff.div_cnt + 10'h1;
        end else begin
            nxt_r.base_cnt = r_ff.base_cnt + 21'h1;
        end

        rate_eff  = (r_ff.state == mrs_pkg::mrs_print) ? `MRS_RATE_PRINT : r_ff.rate_cur;
        rate_mask = 10'((11'h1 << rate_eff) - 11'h1);
        sweep_pls = base_pls && ((r_ff.div_cnt & rate_mask) == rate_mask);
        // rate off hands the sweep to the manual advance button
        advance   = (rate_eff == `MRS_RATE_OFF) ? adv_pls : sweep_pls;

        // print gating from sequence or toggle
        pgate = (r_ff.state == mrs_pkg::mrs_print) || r_ff.sync2[3];

        // relay closes on each new channel
        // each step re-arms the full closure
        if (pgate && advance) begin
            nxt_r.relay_cnt = 15'(RELAY_CYC);
        end else if (r_ff.relay_cnt != 15'h0) begin
            nxt_r.relay_cnt = r_ff.relay_cnt - 15'h1;
        end

        // six-bit scaler stepping and clearing
        // sweep reset beats an advance
        if (swrst_pls) begin
            nxt_r.scaler = 6'h00;
        end else if (advance) begin
            // step past last channel clears scaler
            if (r_ff.scaler >= r_ff.last_chan) begin
                nxt_r.scaler = 6'h00;
            end else begin
                nxt_r.scaler = r_ff.scaler + 6'h01;
            end
        end

        // selected integration time
        case (r_ff.time_sel)
            2'h0:    t_target = `MRS_T_SEL0;
            2'h1:    t_target = `MRS_T_SEL1;
            2'h2:    t_target = `MRS_T_SEL2;
            default: t_target = `MRS_T_SEL3;
        endcase

        nxt_r.eor = 1'b0;

        // sequencer
        case (r_ff.state)
            mrs_pkg::mrs_clear: begin
                // hold reset for several discharge constants
                if (r_ff.rst_cnt == 24'(INTEG_RST_CYC - 1)) begin
                    nxt_r.state = mrs_pkg::mrs_integ;
                end else begin
                    nxt_r.rst_cnt = r_ff.rst_cnt + 24'h1;
                end
            end

            // timer runs only here
            mrs_pkg::mrs_integ: begin
                // count seconds up to the selection
                if (tick_pls) begin
                    nxt_r.sec_cnt = r_ff.sec_cnt + 10'h1;
                    // compare the count about to be stored
                    if (r_ff.sec_cnt + 10'h1 == t_target) begin
                        nxt_r.state  = mrs_pkg::mrs_print;
                        // scaler at zero, first step shows channel one
                        nxt_r.scaler = 6'h00;
                    end
                end
            end

            // slow sweep with gating on
            mrs_pkg::mrs_print: begin
                if (advance && !swrst_pls && r_ff.scaler + 6'h01 == r_ff.last_chan) begin
                    nxt_r.eor = 1'b1;

                    if (r_ff.sync2[4]) begin
                        nxt_r.state = mrs_pkg::mrs_clear;
                        nxt_r.rst_cnt = 24'h0;
                        nxt_r.sec_cnt = 10'h0;
                        nxt_r.rate_cur = r_ff.rate_sel;
                    end else begin
                        nxt_r.state = mrs_pkg::mrs_hold;
                    end
                end
            end

            // everything else parks
            default: begin
                // idle and hold wait for start
                nxt_r.state = r_ff.state;
            end
        endcase

        if (start_pls) begin
            // reset integrators and timer, load rate
            nxt_r.state    = mrs_pkg::mrs_clear;
            nxt_r.rst_cnt  = 24'h0;
            nxt_r.sec_cnt  = 10'h0;
            nxt_r.rate_cur = r_ff.rate_sel;
        end

        // status word for reads
        rd_word = 32'h0;
        hold_lvl = (r_ff.state != mrs_pkg::mrs_clear) && (r_ff.state != mrs_pkg::mrs_integ);
        // decoded in the address phase
        if (haddr[5:0] == `MRS_CTRL_OFS) begin
            rd_word[`MRS_CTRL_AUTO_BIT]                     = r_ff.auto_en;
            rd_word[`MRS_CTRL_RATE_MSB:`MRS_CTRL_RATE_LSB] = r_ff.rate_sel;
            rd_word[`MRS_CTRL_TSEL_MSB:`MRS_CTRL_TSEL_LSB] = r_ff.time_sel;
            rd_word[`MRS_CTRL_LAST_MSB:`MRS_CTRL_LAST_LSB] = r_ff.last_chan;
        end else if (haddr[5:0] == `MRS_STATUS_OFS) begin
            rd_word[`MRS_ST_STATE_MSB:`MRS_ST_STATE_LSB] = r_ff.state;
            rd_word[`MRS_ST_HOLD_BIT]                    = hold_lvl;
            rd_word[`MRS_ST_PGATE_BIT]                   = pgate;
            rd_word[`MRS_ST_SCAL_MSB:`MRS_ST_SCAL_LSB]   = r_ff.scaler;
            rd_word[`MRS_ST_SEC_MSB:`MRS_ST_SEC_LSB]     = r_ff.sec_cnt;
        end

        // hsize ignored: only whole words are mapped
        // address phase; read data registered for the data phase
        nxt_r.ph_valid = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1]) begin
            nxt_r.ph_write = hwrite;
            nxt_r.ph_addr  = haddr[5:0];
            if (!hwrite) begin
                nxt_r.rdata = rd_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_ff           <= '0;
            // control fields wake at their defaults
            r_ff.state     <= mrs_pkg::mrs_idle;
            r_ff.auto_en   <= `MRS_RST_AUTO;
            r_ff.rate_sel  <= `MRS_RST_RATE;
            r_ff.rate_cur  <= `MRS_RST_RATE;
            r_ff.time_sel  <= `MRS_RST_TSEL;
            r_ff.last_chan <= `MRS_MAX_CHAN;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero-wait slave, always okay; size is not checked, whole words only
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = r_ff.rdata;

    assign integ_reset    = (r_ff.state == mrs_pkg::mrs_clear);
    assign integ_hold     = (r_ff.state != mrs_pkg::mrs_clear) &&
                            (r_ff.state != mrs_pkg::mrs_integ);

    // detectors alternate, both open in hold
    assign det_sw_sig     = !integ_hold && r_ff.sync2[6];
    assign det_sw_ref     = !integ_hold && !r_ff.sync2[6];

    assign print_gate     = (r_ff.state == mrs_pkg::mrs_print) || r_ff.sync2[3];
    assign print_relay    = (r_ff.relay_cnt != 15'h0);
    assign end_of_readout = r_ff.eor;

    assign lamp_code      = r_ff.scaler;
    assign dac_code       = r_ff.scaler;

    assign gate_drv.true_lvl = r_ff.scaler;
    assign gate_drv.comp_lvl = ~r_ff.scaler;

    // ----------------------------------------------------------------
    // channel gates
    // ----------------------------------------------------------------
    for (genvar c = 0; c < 52; c++) begin : g_chan
        assign chan_sel[c]  = (r_ff.scaler == 6'(c + 1));

        assign gated_out[c] = chan_sel[c] ? integ_val[c] : 8'h00;
    end

endmodule : mrs_sequencer
`default_nettype wire

// >>> logic/mrs_regs.svh
// register map, field positions, reset values and timing constants of the readout sequencer
// Notes on behaviour
// - start clears integrators, timer, loads sweep rate
// - integrate for exactly the selected time
// - hold asserted until next start or recycle
// - hold enables print gating, slowest sweep rate
// - printing sweep starts at channel one
// - last channel ends gating, restores preset rate
// - afterwards hold, display at preset rate
// - gated sweep pulses close printer relay
// - print-force toggle also enables print gating
// - gate selected when scaler equals channel number
// - scaler bits driven true and complemented
// - lamps show current channel in binary
// - scaler value feeds horizontal position converter
// - channel count configurable one to 52
// - last channel ends readout, next resets scaler
// - recycle switch restarts integration without start
// - gated output zero unless select active
// - integrator reset long enough to discharge
// - detector switches alternate, zero during hold
// - six-bit scaler, cleared by reset or end
// - timer counts seconds to 1/10/300/900
// - power-of-two sweep rates, print uses 1024
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MRS_CTRL_OFS        6'h00
`define MRS_STATUS_OFS      6'h04
`define MRS_CMD_OFS         6'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MRS_CTRL_AUTO_BIT   0
`define MRS_CTRL_RATE_LSB   1
`define MRS_CTRL_RATE_MSB   4
`define MRS_CTRL_TSEL_LSB   5
`define MRS_CTRL_TSEL_MSB   6
`define MRS_CTRL_LAST_LSB   8
`define MRS_CTRL_LAST_MSB   13
`define MRS_CMD_START_BIT   0
`define MRS_CMD_SWRST_BIT   1
`define MRS_ST_STATE_LSB    0
`define MRS_ST_STATE_MSB    2
`define MRS_ST_HOLD_BIT     3
`define MRS_ST_PGATE_BIT    4
`define MRS_ST_SCAL_LSB     8
`define MRS_ST_SCAL_MSB     13
`define MRS_ST_SEC_LSB      16
`define MRS_ST_SEC_MSB      25

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define MRS_RST_AUTO        1'h1
`define MRS_RST_RATE        4'h1
`define MRS_RST_TSEL        2'h2
`define MRS_MAX_CHAN        6'h34
`define MRS_RATE_OFF        4'h0
`define MRS_RATE_PRINT      4'hA
`define MRS_T_SEL0          10'h001
`define MRS_T_SEL1          10'h00A
`define MRS_T_SEL2          10'h12C
`define MRS_T_SEL3          10'h384

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MRS_CLK_MHZ         250
`define MRS_SWEEP_PER_US    1500
`define MRS_DISCH_TC_MS     10
`define MRS_DISCH_TC_NUM    5
`define MRS_RELAY_US        100
`define MRS_DEBOUNCE_MS     5

`endif

// >>> logic/mrs_pkg.sv
// types shared by the readout sequencer
`default_nettype none
package mrs_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        mrs_idle,
        mrs_clear,
        mrs_integ,
        mrs_print,
        mrs_hold
    } mrs_state_t;

    // scaler bits toward the diode gate drivers
    typedef struct packed {
        logic [5:0] true_lvl;   // one drives the positive level
        logic [5:0] comp_lvl;   // complement of the same bits
    } mrs_gate_drv_t;

    // all state of the sequencer
    typedef struct packed {
        mrs_state_t  state;
        logic [6:0]  sync1;        // first synchroniser stage
        logic [6:0]  sync2;        // second synchroniser stage
        logic [2:0]  btn_level;    // debounced pushbutton levels
        logic [2:0][20:0] deb_cnt; // per-button stability counters
        logic        tick_prev;
        logic [9:0]  sec_cnt;
        logic [23:0] rst_cnt;
        logic [20:0] base_cnt;
        logic [9:0]  div_cnt;
        logic [5:0]  scaler;
        logic [3:0]  rate_cur;
        logic [14:0] relay_cnt;
        logic        eor;
        logic        auto_en;
        logic [3:0]  rate_sel;
        logic [1:0]  time_sel;
        logic [5:0]  last_chan;
        logic        ph_valid;
        logic        ph_write;
        logic [5:0]  ph_addr;
        logic [31:0] rdata;
    } mrs_regs_t;

endpackage : mrs_pkg
`default_nettype wire

// >>> dv/mrs_seq_assertions.sv
// concurrent checks on the readout sequencer outputs, bound to its top
`default_nettype none
module mrs_seq_assertions #(
    parameter int INTEG_RST_CYC = 8
) (
    // clock and reset
    input wire logic                   hclk,
    input wire logic                   hresetn,
    // integrator side
    input wire logic [51:0][7:0]       integ_val,
    input wire logic                   integ_reset,
    input wire logic                   integ_hold,
    input wire logic                   det_sw_sig,
    input wire logic                   det_sw_ref,
    // readout side
    input wire logic                   print_gate,
    input wire logic                   print_relay,
    input wire logic                   end_of_readout,
    input wire logic [5:0]             lamp_code,
    input wire logic [5:0]             dac_code,
    input wire mrs_pkg::mrs_gate_drv_t gate_drv,
    input wire logic [51:0]            chan_sel,
    input wire logic [51:0][7:0]       gated_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // helper: length of the current integrator clear
    // ----------------
    logic [23:0] rst_run_ff;  // cleared whenever reset output drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_run_ff <= 24'h000000;
        end else begin
            rst_run_ff <= integ_reset ? rst_run_ff + 24'h000001 : 24'h000000;
        end
    end
    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    gate_comp_a: assert property (gate_drv.comp_lvl == ~gate_drv.true_lvl)
        else $error("complement gate drive wrong");
    chan_decode_a: assert property (chan_sel == ((gate_drv.true_lvl == 6'h00) ? 52'h0
        : (52'h1 << (gate_drv.true_lvl - 6'h01)))) else $error("channel select decode wrong");
    gated_zero_a: assert property (chan_sel == 52'h0 |-> gated_out == '0)
        else $error("gated output not zero");
    gated_pass_a: assert property (chan_sel[2] |-> gated_out[2] == integ_val[2])
        else $error("gated output not passed");
    lamp_dac_a: assert property (lamp_code == dac_code)
        else $error("lamp and position codes differ");
    hold_quiet_a: assert property (integ_hold |-> !det_sw_sig && !det_sw_ref)
        else $error("detector switch active in hold");
    sw_alternate_a: assert property (!integ_hold |-> det_sw_sig != det_sw_ref)
        else $error("detector switches not complementary");
    rst_length_a: assert property ($fell(integ_reset) |-> rst_run_ff == INTEG_RST_CYC)
        else $error("integrator clear length wrong");
    // relay width follows the bench value of three cycles
    relay_pulse_a: assert property ($rose(print_relay) |-> $past(print_gate)
        ##0 print_relay[*3] ##1 !print_relay) else $error("relay closure wrong");
    eor_single_a: assert property (end_of_readout |=> !end_of_readout)
        else $error("end of readout not single");
    cover property (end_of_readout);
    cover property ($rose(print_relay));
    cover property ($fell(integ_reset));
endmodule : mrs_seq_assertions

bind mrs_sequencer mrs_seq_assertions #(.INTEG_RST_CYC(INTEG_RST_CYC)) u_chk (.*);
`default_nettype wire

// >>> dv/mrs_printer_model.sv
// printer relay model: counts contact closures and latches the printed value
`default_nettype none
module mrs_printer_model (
    // clock
    input wire logic               hclk,
    // relay contact and printer socket
    input wire logic               print_relay,
    input wire logic [51:0][7:0]   gated_out,
    // observation
    output int                     closures,
    output logic [7:0]             printed
);
    timeunit 1ns;
    timeprecision 100ps;
    logic relay_q;  // last relay level, for edge detection
    initial begin
        closures = 0;
        printed = 8'h00;
        relay_q = 1'b0;
    end
    always @(posedge hclk) begin
        logic [7:0] v;
        v = 8'h00;
        // only one channel may be gated at once, so an or is enough
        for (int c = 0; c < 52; c++) v = v | gated_out[c];
        relay_q <= print_relay;
        if (print_relay && !relay_q) begin
            closures <= closures + 1;
            printed <= v;
        end
    end
endmodule : mrs_printer_model
`default_nettype wire

// >>> dv/tb_multichannel_readout_sequencer.sv
// self-checking bench for the readout sequencer
`include "mrs_regs.svh"
`default_nettype none
module tb_multichannel_readout_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // signals
    // ----------------
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic start_btn, sweep_rst_btn, man_adv_btn, print_force_sw, recycle_sw;
    logic tick_1hz, sig_ref_sw, integ_reset, integ_hold, det_sw_sig, det_sw_ref;
    logic print_gate, print_relay, end_of_readout;
    logic [5:0] lamp_code, dac_code;
    mrs_pkg::mrs_gate_drv_t gate_drv;
    logic [51:0] chan_sel;
    logic [51:0][7:0] integ_val, gated_out;
    logic [7:0] printed;
    int closures, fails, checks_done;
    // counts shortened so the run stays brief
    mrs_sequencer #(.SWEEP_PER_CYC(4), .INTEG_RST_CYC(8), .RELAY_CYC(3), .DEBOUNCE_CYC(3)) u_dut (
        .*, .hready(hreadyout));
    mrs_printer_model u_prn (.*);
    // ----------------
    // clock and reference square wave
    // ----------------
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always begin
        repeat (8) @(posedge hclk);
        sig_ref_sw <= ~sig_ref_sw;
    end
    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // bounded wait; a wait that runs out ends the run
    task automatic wait_on(ref logic s, input logic v, input int n);
        int k;
        k = 0;
        while (s !== v && k < n) begin
            @(posedge hclk);
            #1;
            k++;
        end
        if (s !== v) begin
            fails++;
            $display("CHECK FAILED wait expected %b seen %b", v, s);
            final_report();
        end
    endtask : wait_on
    // single ahb-lite word transfer
    task automatic ahb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {26'h0, a};
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 100);
        rv = hrdata;
        if (k >= 100) begin
            fails++;
            $display("CHECK FAILED ahb ready expected 1 seen %b", hreadyout);
            final_report();
        end
    endtask : ahb
    // each second tick is a short pulse on the asynchronous input
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge hclk);
            tick_1hz <= 1'b1;
            repeat (4) @(posedge hclk);
            tick_1hz <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask : tick
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        ahb(1'b0, `MRS_CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h00003443, rv);
        ahb(1'b0, `MRS_STATUS_OFS, 32'h0);
        chk("status reset", 32'h00000008, rv);
        ahb(1'b0, 6'h10, 32'h0);
        chk("unmapped read", 32'h0, rv);
        chk("okay response", 32'h0, hresp);
    endtask : t_reset
    // full automatic cycle over three channels with a given time code
    task automatic t_cycle(input logic [1:0] ts, input int n);
        int c0;
        int chg;
        logic [5:0] l0;
        ahb(1'b1, `MRS_CTRL_OFS, {18'h0, 6'h03, 1'b0, ts, 4'h1, 1'b1});
        ahb(1'b1, `MRS_CMD_OFS, 32'h1);
        wait_on(integ_reset, 1'b1, 10);
        wait_on(integ_reset, 1'b0, 20);
        tick(n - 1);
        #1;
        chk("hold before time", 32'h0, integ_hold);
        tick(1);
        wait_on(print_gate, 1'b1, 20);
        chk("hold after time", 32'h1, integ_hold);
        c0 = closures;
        wait_on(end_of_readout, 1'b1, 20000);
        chk("last channel", 32'h3, lamp_code);
        repeat (6) @(posedge hclk);
        #1;
        chk("gate after print", 32'h0, print_gate);
        chk("relay closures", 32'h3, closures - c0);
        chk("printed value", 32'h3, printed);
        chg = 0;
        l0 = lamp_code;
        repeat (64) begin
            @(posedge hclk);
            #1;
            if (lamp_code !== l0) chg++;
            l0 = lamp_code;
        end
        chk("display sweep", 32'h1, chg >= 4);
    endtask : t_cycle
    task automatic t_recycle();
        @(posedge hclk);
        recycle_sw <= 1'b1;
        ahb(1'b1, `MRS_CTRL_OFS, 32'h00000303);
        ahb(1'b1, `MRS_CMD_OFS, 32'h1);
        wait_on(integ_reset, 1'b1, 10);
        wait_on(integ_reset, 1'b0, 20);
        tick(1);
        wait_on(end_of_readout, 1'b1, 20000);
        wait_on(integ_reset, 1'b1, 10);
        @(posedge hclk);
        recycle_sw <= 1'b0;
    endtask : t_recycle
    task automatic t_abort();
        wait_on(integ_reset, 1'b0, 20);
        tick(1);
        wait_on(print_gate, 1'b1, 20);
        repeat (200) @(posedge hclk);
        start_btn <= 1'b1;
        wait_on(integ_reset, 1'b1, 20);
        chk("gate on abort", 32'h0, print_gate);
        @(posedge hclk);
        start_btn <= 1'b0;
    endtask : t_abort
    task automatic t_force();
        @(posedge hclk);
        print_force_sw <= 1'b1;
        wait_on(print_gate, 1'b1, 10);
        ahb(1'b1, `MRS_CMD_OFS, 32'h2);
        #1;
        chk("sweep reset", 32'h0, lamp_code);
        @(posedge hclk);
        print_force_sw <= 1'b0;
    endtask : t_force
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    // ----------------
    // main sequence
    // ----------------
    initial begin
        int tv[4] = '{1, 10, 300, 900};
        {hresetn, hsel, hwrite, start_btn, sweep_rst_btn, man_adv_btn} = 6'h00;
        {print_force_sw, recycle_sw, tick_1hz, sig_ref_sw} = 4'h0;
        {haddr, hwdata, htrans, hsize} = 69'h0;
        fails = 0;
        checks_done = 0;
        for (int c = 0; c < 52; c++) integ_val[c] = 8'(c + 1);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        for (int i = 0; i < 4; i++) t_cycle(2'(i), tv[i]);
        t_recycle();
        t_abort();
        t_force();
        final_report();
    end
endmodule : tb_multichannel_readout_sequencer
`default_nettype wire
